// [hdl/cehb_top.v]
// host-side control of the codec engine: registers, commands,
// stream buffer pointers and interrupt reasons
// assumes register port strobes are one cycle and never overlap
`timescale 1ns/100ps
`include "cehb_consts.vh"
module cehb_top #(
	parameter AW = 32,
	parameter NINST = 4
)(
	input wire core_clk,
	input wire rst,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata_q,
	input wire op_done,
	input wire core_rd_valid,
	input wire [AW-1:0] core_rd_bytes,
	input wire [1:0] core_inst,
	input wire [AW-1:0] save_used,
	output reg irq_q,
	output reg core_run_q,
	output reg [3:0] core_cmd_q,
	output reg reload_q,
	output reg stream_stall_q,
	output reg stream_endian_q,
	output reg stream_check_q
);
	// ----------------------------------------
	// core states and storage
	// ----------------------------------------
	localparam ST_HALT = 2'h0;
	localparam ST_INIT = 2'h1;
	localparam ST_IDLE = 2'h2;
	localparam ST_CMD = 2'h3;

	reg [1:0] st_q;
	reg [15:0] cnt_q;
	reg [AW-1:0] code_base_q, work_base_q, param_base_q;
	reg [1:0] sc_q;
	reg [NINST-1:0] ring_q;
	reg [1:0] inst_q;
	reg [3:0] cmd_q;
	reg busy_q;
	reg [`CEHB_IRQ_W-1:0] en_q, reason_q;
	reg [AW-1:0] start_q, end_q, rd_q, wr_q, save_lim_q;
	reg [3:0] std_q, loaded_std_q;
	reg reload_done_q;
	reg [`CEHB_IRQ_W-1:0] ev;
	reg [AW-1:0] wr_step;
	wire [AW-1:0] wr_next, rd_next, fill;
	wire ring_cur;
	wire is_wr, is_rd;

	// ----------------------------------------
	// strobe decode, both strobes at once ignored
	// ----------------------------------------
	assign is_wr = reg_wr && !reg_rd;
	assign is_rd = reg_rd && !reg_wr;
	assign ring_cur = ring_q[core_inst];

	// ----------------------------------------
	// command to reason bit
	// ----------------------------------------
	function [3:0] cmd_bit;
		input [3:0] c;
		case (c)
			`CEHB_CMD_SEQ_INIT: cmd_bit = 4'd`CEHB_IRQ_SEQ_INIT;
			`CEHB_CMD_SEQ_END: cmd_bit = 4'd`CEHB_IRQ_SEQ_END;
			`CEHB_CMD_PIC_RUN: cmd_bit = 4'd`CEHB_IRQ_PIC_DEC;
			`CEHB_CMD_SET_FB: cmd_bit = 4'd`CEHB_IRQ_FB_REG;
			`CEHB_CMD_PARA_SET: cmd_bit = 4'd`CEHB_IRQ_PARAM_SET;
			`CEHB_CMD_FLUSH: cmd_bit = 4'd`CEHB_IRQ_FLUSH;
			// quick commands get no reason bit
			default: cmd_bit = 4'hf;
		endcase
	endfunction

	// ----------------------------------------
	// ring pointer helpers
	// ----------------------------------------
	always @*
	begin
		wr_step = (is_wr && reg_addr == `CEHB_REG_WR_ADD) ? reg_wdata[AW-1:0] : {AW{1'b0}};
	end

	// host chunk notification advances the write pointer
	cehb_ring_ptr #(.AW(AW)) u_wr (
		.buf_start(start_q),
		.buf_end(end_q),
		.ptr(wr_q),
		.step(wr_step),
		.other_ptr(rd_q),
		.ring_mode(ring_q[inst_q]),
		.next_ptr(wr_next),
		.fill(fill)
	);

	// core consumption advances the read pointer
	cehb_ring_ptr #(.AW(AW)) u_rd (
		.buf_start(start_q),
		.buf_end(end_q),
		.ptr(rd_q),
		.step(core_rd_valid ? core_rd_bytes : {AW{1'b0}}),
		.other_ptr(wr_q),
		.ring_mode(ring_cur),
		.next_ptr(rd_next),
		.fill()
	);

	// ----------------------------------------
	// event collection
	// ----------------------------------------
	always @*
	begin
		ev = {`CEHB_IRQ_W{1'b0}};
		if (st_q == ST_INIT && cnt_q == 16'h0000)
			ev[`CEHB_IRQ_RUN_DONE] = 1'b1;
		if (st_q == ST_CMD && op_done && !reload_q && cmd_bit(cmd_q) != 4'hf)
			ev[cmd_bit(cmd_q)] = 1'b1;
		if (sc_q[`CEHB_SC_CHECK_EN] && stream_stall_q)
			ev[`CEHB_IRQ_EMPTY] = 1'b1;
		if (sc_q[`CEHB_SC_CHECK_EN] && fill >= end_q - start_q - 32'h0000_0004)
			ev[`CEHB_IRQ_FULL] = 1'b1;
		if (save_used > save_lim_q)
			ev[`CEHB_IRQ_OVERFLOW] = 1'b1;
	end

	// ----------------------------------------
	// register writes, core sequencing, interrupts
	// ----------------------------------------
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= ST_HALT;
			cnt_q <= 16'h0000;
			code_base_q <= {AW{1'b0}};
			work_base_q <= {AW{1'b0}};
			param_base_q <= {AW{1'b0}};
			sc_q <= `CEHB_SC_RESET;
			ring_q <= {NINST{1'b0}};
			inst_q <= 2'h0;
			cmd_q <= 4'h0;
			busy_q <= 1'b0;
			en_q <= {`CEHB_IRQ_W{1'b0}};
			reason_q <= {`CEHB_IRQ_W{1'b0}};
			start_q <= {AW{1'b0}};
			end_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			wr_q <= {AW{1'b0}};
			save_lim_q <= `CEHB_HDR_SAVE_SIZE;
			std_q <= 4'h0;
			loaded_std_q <= 4'h0;
			reload_done_q <= 1'b0;
			irq_q <= 1'b0;
			core_run_q <= 1'b0;
			core_cmd_q <= 4'h0;
			reload_q <= 1'b0;
			stream_stall_q <= 1'b0;
			stream_endian_q <= 1'b0;
			stream_check_q <= 1'b0;
		end
		else
		begin
			if (is_wr)
			begin
				case (reg_addr)
					`CEHB_REG_CODE_BASE: code_base_q <= reg_wdata[AW-1:0];
					`CEHB_REG_WORK_BASE: work_base_q <= reg_wdata[AW-1:0];
					`CEHB_REG_PARAM_BASE: param_base_q <= reg_wdata[AW-1:0];
					`CEHB_REG_STRM_CTRL: sc_q <= reg_wdata[1:0];
					`CEHB_REG_INST_MODE: ring_q <= reg_wdata[NINST-1:0];
					`CEHB_REG_INT_EN: en_q <= reg_wdata[`CEHB_IRQ_W-1:0];
					`CEHB_REG_BUF_START: start_q <= reg_wdata[AW-1:0];
					`CEHB_REG_BUF_END: end_q <= reg_wdata[AW-1:0];
					`CEHB_REG_RD_PTR: rd_q <= reg_wdata[AW-1:0];
					`CEHB_REG_WR_PTR: wr_q <= reg_wdata[AW-1:0];
					`CEHB_REG_WR_ADD: wr_q <= wr_next;
					`CEHB_REG_SAVE_LIMIT: save_lim_q <= reg_wdata[AW-1:0];
					`CEHB_REG_STD: std_q <= reg_wdata[3:0];
					default: ;
				endcase
			end
			if (core_rd_valid)
				rd_q <= rd_next;
			stream_endian_q <= sc_q[`CEHB_SC_ENDIAN];
			stream_check_q <= sc_q[`CEHB_SC_CHECK_EN];
			// stall while picture or init waits for data
			stream_stall_q <= st_q == ST_CMD && fill == {AW{1'b0}} &&
				(cmd_q == `CEHB_CMD_SEQ_INIT || cmd_q == `CEHB_CMD_PIC_RUN);
			// set wins over clear
			if (is_wr && reg_addr == `CEHB_REG_INT_CLEAR)
				reason_q <= (reason_q & ~reg_wdata[`CEHB_IRQ_W-1:0]) | ev;
			else
				reason_q <= reason_q | ev;
			irq_q <= |(reason_q & en_q);
			case (st_q)
				ST_HALT:
				begin
					if (is_wr && reg_addr == `CEHB_REG_RUN && reg_wdata[0])
					begin
						st_q <= ST_INIT;
						cnt_q <= `CEHB_INIT_CYCLES;
						core_run_q <= 1'b1;
						busy_q <= 1'b1;
						loaded_std_q <= std_q;
					end
				end
				ST_INIT:
				begin
					if (cnt_q == 16'h0000)
					begin
						st_q <= ST_IDLE;
						busy_q <= 1'b0;
					end
					else
						cnt_q <= cnt_q - 16'h0001;
				end
				ST_IDLE:
				begin
					if (is_wr && reg_addr == `CEHB_REG_CMD)
					begin
						cmd_q <= reg_wdata[3:0];
						core_cmd_q <= reg_wdata[3:0];
						busy_q <= 1'b1;
						st_q <= ST_CMD;
						reload_done_q <= 1'b0;
						if (std_q != loaded_std_q)
						begin
							reload_q <= 1'b1;
							cnt_q <= `CEHB_RELOAD_CYCLES;
						end
					end
				end
				ST_CMD:
				begin
					if (reload_q)
					begin
						if (cnt_q == 16'h0000)
						begin
							reload_q <= 1'b0;
							reload_done_q <= 1'b1;
							loaded_std_q <= std_q;
						end
						else
							cnt_q <= cnt_q - 16'h0001;
					end
					else if (op_done)
					begin
						busy_q <= 1'b0;
						core_cmd_q <= 4'h0;
						st_q <= ST_IDLE;
					end
				end
				default: st_q <= ST_HALT;
			endcase
			if (is_wr && reg_addr == `CEHB_REG_RUN && !reg_wdata[0])
			begin
				st_q <= ST_HALT;
				core_run_q <= 1'b0;
				busy_q <= 1'b0;
				reload_q <= 1'b0;
				core_cmd_q <= 4'h0;
			end
		end
	end

	// ----------------------------------------
	// register reads, data one cycle after strobe
	// ----------------------------------------
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
			reg_rdata_q <= 32'h0000_0000;
		else if (is_rd)
		begin
			case (reg_addr)
				`CEHB_REG_RUN: reg_rdata_q <= {31'h0, core_run_q};
				`CEHB_REG_CODE_BASE: reg_rdata_q <= code_base_q;
				`CEHB_REG_WORK_BASE: reg_rdata_q <= work_base_q;
				`CEHB_REG_PARAM_BASE: reg_rdata_q <= param_base_q;
				`CEHB_REG_STRM_CTRL: reg_rdata_q <= {30'h0, sc_q};
				`CEHB_REG_INST_MODE: reg_rdata_q <= {{(32-NINST){1'b0}}, ring_q};
				`CEHB_REG_CMD: reg_rdata_q <= {28'h0, cmd_q};
				`CEHB_REG_BUSY: reg_rdata_q <= {31'h0, busy_q};
				`CEHB_REG_INT_EN: reg_rdata_q <= {22'h0, en_q};
				`CEHB_REG_INT_REASON: reg_rdata_q <= {22'h0, reason_q};
				`CEHB_REG_BUF_START: reg_rdata_q <= start_q;
				`CEHB_REG_BUF_END: reg_rdata_q <= end_q;
				`CEHB_REG_RD_PTR: reg_rdata_q <= rd_q;
				`CEHB_REG_WR_PTR: reg_rdata_q <= wr_q;
				`CEHB_REG_SAVE_LIMIT: reg_rdata_q <= save_lim_q;
				`CEHB_REG_STATUS: reg_rdata_q <= {27'h0, reload_done_q, reload_q,
					stream_stall_q, st_q};
				`CEHB_REG_STD: reg_rdata_q <= {24'h0, loaded_std_q, std_q};
				default: reg_rdata_q <= 32'h0000_0000;
			endcase
		end
		else
			reg_rdata_q <= 32'h0000_0000;
	end
endmodule

// [hdl/cehb_consts.vh]
// constants for the codec engine host buffer and interrupt block
// assumes a plain register port, one clock, active-high async reset
//
// Behaviour
// - engine reports save buffer overflow
// - engine reloads program, at most once per picture
// - stream control holds endian and check enable
// - ring or line mode per decoder instance for the read pointer; the write pointer always follows instance 0
// - ring pointers wrap at buffer end
// - completion and stream empty/full interrupts
// - quick commands raise no completion interrupt
// - init and decode stall on missing bitstream
// - one enable bit per interrupt source
// - reason register names interrupt source
// - readable busy flag for polling
// - run register at 0x000 halts or starts core
`ifndef CEHB_CONSTS_VH
`define CEHB_CONSTS_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CEHB_REG_RUN 8'h00
`define CEHB_REG_CODE_BASE 8'h04
`define CEHB_REG_WORK_BASE 8'h08
`define CEHB_REG_PARAM_BASE 8'h0c
`define CEHB_REG_STRM_CTRL 8'h10
`define CEHB_REG_INST_MODE 8'h14
`define CEHB_REG_CMD 8'h18
`define CEHB_REG_BUSY 8'h1c
`define CEHB_REG_INT_EN 8'h20
`define CEHB_REG_INT_REASON 8'h24
`define CEHB_REG_INT_CLEAR 8'h28
`define CEHB_REG_BUF_START 8'h2c
`define CEHB_REG_BUF_END 8'h30
`define CEHB_REG_RD_PTR 8'h34
`define CEHB_REG_WR_PTR 8'h38
`define CEHB_REG_WR_ADD 8'h3c
`define CEHB_REG_SAVE_LIMIT 8'h40
`define CEHB_REG_STATUS 8'h44
`define CEHB_REG_STD 8'h48

// ----------------------------------------
// region sizes in bytes
// ----------------------------------------
`define CEHB_CODE_REGION_SIZE 32'h0002_1000
`define CEHB_WORK_REGION_SIZE 32'h0004_0000
`define CEHB_PARAM_REGION_SIZE 32'h0000_2000
`define CEHB_HDR_SAVE_SIZE 32'h0000_1400

// ----------------------------------------
// stream control fields
// ----------------------------------------
`define CEHB_SC_ENDIAN 0
`define CEHB_SC_CHECK_EN 1
`define CEHB_SC_RESET 2'h0

// ----------------------------------------
// interrupt source bit positions
// ----------------------------------------
`define CEHB_IRQ_RUN_DONE 0
`define CEHB_IRQ_SEQ_INIT 1
`define CEHB_IRQ_SEQ_END 2
`define CEHB_IRQ_PIC_DEC 3
`define CEHB_IRQ_FB_REG 4
`define CEHB_IRQ_PARAM_SET 5
`define CEHB_IRQ_FLUSH 6
`define CEHB_IRQ_EMPTY 7
`define CEHB_IRQ_FULL 8
`define CEHB_IRQ_OVERFLOW 9
`define CEHB_IRQ_W 10

// ----------------------------------------
// command codes
// ----------------------------------------
`define CEHB_CMD_SEQ_INIT 4'h1
`define CEHB_CMD_SEQ_END 4'h2
`define CEHB_CMD_PIC_RUN 4'h3
`define CEHB_CMD_SET_FB 4'h4
`define CEHB_CMD_PARA_SET 4'h5
`define CEHB_CMD_FLUSH 4'h6
`define CEHB_CMD_QUICK 4'h7

// ----------------------------------------
// timing: core init and program reload in cycles
// ----------------------------------------
`define CEHB_INIT_CYCLES 16'h0040
`define CEHB_RELOAD_CYCLES 16'h0020

`endif

// [hdl/cehb_ring_ptr.v]
// ring buffer pointer arithmetic: advance with wrap, fill level
// assumes start below end, both byte addresses
`timescale 1ns/100ps
module cehb_ring_ptr #(
	parameter AW = 32
)(
	input wire [AW-1:0] buf_start,
	input wire [AW-1:0] buf_end,
	input wire [AW-1:0] ptr,
	input wire [AW-1:0] step,
	input wire [AW-1:0] other_ptr,
	input wire ring_mode,
	output reg [AW-1:0] next_ptr,
	output reg [AW-1:0] fill
);
	reg [AW-1:0] raw;
	reg [AW-1:0] size;
	always @*
	begin
		raw = ptr + step;
		size = buf_end - buf_start;
		if (ring_mode && raw >= buf_end)
			next_ptr = raw - size;
		else
			next_ptr = raw;
		// fill seen from other_ptr (reader) to ptr (writer)
		if (ptr >= other_ptr)
			fill = ptr - other_ptr;
		else
			fill = size - (other_ptr - ptr);
	end
endmodule

// [bench/cehb_core_sim.sv]
// sequencer core stand-in: answers each issued command with op_done
// assumes cehb_top outputs; lat sets the answer delay in cycles
`timescale 1ns/100ps
module cehb_core_sim (
	input wire clk,
	input wire rst,
	input wire [3:0] cmd,
	input wire reload,
	input wire stall,
	input wire [3:0] lat,
	output reg op_done
);
	reg [3:0] cnt_q;
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			op_done <= 1'b0;
			cnt_q <= 4'h0;
		end
		else
		begin
			op_done <= 1'b0;
			if (cmd == 4'h0 || op_done)
				cnt_q <= 4'h0;
			// no answer while program reloads or stream runs dry
			else if (!reload && !stall)
			begin
				if (cnt_q == lat)
					op_done <= 1'b1;
				else
					cnt_q <= cnt_q + 4'h1;
			end
		end
	end
endmodule

// [bench/cehb_top_chk.sv]
// port checker for cehb_top
// assumes one clock domain, async active-high reset
`timescale 1ns/100ps
module cehb_chk (
	input wire core_clk,
	input wire rst,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata_q,
	input wire op_done,
	input wire irq_q,
	input wire core_run_q,
	input wire [3:0] core_cmd_q,
	input wire reload_q,
	input wire stream_stall_q,
	input wire stream_endian_q,
	input wire stream_check_q
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_reload_hold;
		reload_q [*8] ##[24:27] !reload_q;
	endsequence
	chk_run_follow: assert property (reg_wr && !reg_rd && reg_addr == 8'h00
		|=> core_run_q == $past(reg_wdata[0])) else $error("run enable not taken");
	chk_ctrl_copy: assert property (reg_wr && !reg_rd && reg_addr == 8'h10 |-> ##2
		stream_endian_q == $past(reg_wdata[0], 2) && stream_check_q == $past(reg_wdata[1], 2))
		else $error("stream control not applied");
	chk_rdata_idle: assert property (!reg_rd |=> reg_rdata_q == 32'h0)
		else $error("read data outside read slot");
	chk_busy_read: assert property (reg_rd && reg_addr == 8'h1c && core_cmd_q != 4'h0
		|=> reg_rdata_q[0]) else $error("busy not shown during command");
	chk_cmd_clear: assert property (core_cmd_q != 4'h0 && op_done && !reload_q
		|=> core_cmd_q == 4'h0) else $error("command not retired");
	chk_cmd_hold: assert property (core_cmd_q != 4'h0 && !op_done && !(reg_wr && reg_addr == 8'h00)
		|=> $stable(core_cmd_q)) else $error("command changed while busy");
	chk_cmd_running: assert property (core_cmd_q != 4'h0 |-> core_run_q)
		else $error("command while halted");
	chk_irq_masked: assert property (reg_wr && !reg_rd && reg_addr == 8'h20
		&& reg_wdata[9:0] == 10'h0 |-> ##2 !irq_q) else $error("irq despite no enables");
	chk_reload_len: assert property ($rose(reload_q) |-> s_reload_hold)
		else $error("reload length wrong");
	chk_stall_cause: assert property (stream_stall_q |-> core_cmd_q == 4'h1 || core_cmd_q == 4'h3)
		else $error("stall outside init or decode");
endmodule
bind cehb_top cehb_chk cehb_chk_inst (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata_q, .op_done, .irq_q, .core_run_q, .core_cmd_q, .reload_q, .stream_stall_q,
	.stream_endian_q, .stream_check_q);

// [bench/tb_top.sv]
// self-checking bench for cehb_top over its register port
// assumes cehb_consts.vh on the include path
`timescale 1ns/100ps
`include "cehb_consts.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
	$display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
	logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, op_done, core_rd_valid = 0, irq_q;
	logic core_run_q, reload_q, stream_stall_q, stream_endian_q, stream_check_q;
	logic [7:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0, reg_rdata_q, core_rd_bytes = 0, save_used = 0;
	logic [31:0] base = 32'h0010_0000;
	logic [1:0] core_inst = 2'h0;
	logic [3:0] core_cmd_q, lat = 4'h2;
	int miscompares = 0, n_compared = 0, c, i, seen;
	always #25 core_clk = ~core_clk;
	cehb_top cehb_top_inst (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.op_done(op_done), .core_rd_valid(core_rd_valid), .core_rd_bytes(core_rd_bytes),
		.core_inst(core_inst), .save_used(save_used), .irq_q(irq_q), .core_run_q(core_run_q),
		.core_cmd_q(core_cmd_q), .reload_q(reload_q), .stream_stall_q(stream_stall_q),
		.stream_endian_q(stream_endian_q), .stream_check_q(stream_check_q));
	cehb_core_sim cehb_core_sim_inst (.clk(core_clk), .rst(rst), .cmd(core_cmd_q),
		.reload(reload_q), .stall(stream_stall_q), .lat(lat), .op_done(op_done));
	task conclude;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task wr(input [7:0] a, input [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task rdv(input [7:0] a, output [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata_q;
	endtask
	task rd(input [7:0] a, input [31:0] e);
		logic [31:0] v;
		rdv(a, v);
		`CHK(v, e)
	endtask
	task consume(input [1:0] inst, input [31:0] n);
		core_inst <= inst;
		core_rd_valid <= 1'b1;
		core_rd_bytes <= n;
		@(posedge core_clk);
		core_rd_valid <= 1'b0;
	endtask
	task wait_idle;
		logic [31:0] v;
		v = 1;
		for (int k = 0; k < 300 && v[0] !== 1'b0; k++)
			rdv(`CEHB_REG_BUSY, v);
		if (v[0] !== 1'b0)
		begin
			miscompares++;
			$display("mismatch t=%0t busy stuck", $time);
			conclude;
		end
	endtask
	task issue(input [3:0] cmd);
		wr(`CEHB_REG_CMD, {28'h0, cmd});
		seen = 0;
		for (i = 0; i < 8; i++)
		begin
			@(posedge core_clk);
			if (reload_q === 1'b1)
				seen = 1;
		end
		wait_idle;
	endtask
	initial
	begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		rd(`CEHB_REG_BUSY, 0);
		rd(8'hfc, 0);
		rd(`CEHB_REG_SAVE_LIMIT, 32'h1400);
		wr(`CEHB_REG_SAVE_LIMIT, `CEHB_HDR_SAVE_SIZE);
		wr(`CEHB_REG_CODE_BASE, base);
		base = base + `CEHB_CODE_REGION_SIZE;
		wr(`CEHB_REG_WORK_BASE, base);
		base = base + `CEHB_WORK_REGION_SIZE;
		wr(`CEHB_REG_PARAM_BASE, base);
		rd(`CEHB_REG_CODE_BASE, 32'h0010_0000);
		rd(`CEHB_REG_WORK_BASE, 32'h0012_1000);
		rd(`CEHB_REG_PARAM_BASE, 32'h0016_1000);
		wr(`CEHB_REG_STRM_CTRL, 3);
		rd(`CEHB_REG_STRM_CTRL, 3);
		`CHK({stream_check_q, stream_endian_q}, 2'h3)
		wr(`CEHB_REG_STRM_CTRL, 1);
		wr(`CEHB_REG_CMD, 3);
		#1 `CHK(core_cmd_q, 4'h0)
		wr(`CEHB_REG_INT_EN, 32'h3ff);
		wr(`CEHB_REG_STD, 0);
		wr(`CEHB_REG_RUN, 1);
		#1 `CHK(core_run_q, 1'b1)
		rd(`CEHB_REG_BUSY, 1);
		wait_idle;
		rd(`CEHB_REG_INT_REASON, 1);
		`CHK(irq_q, 1'b1)
		wr(`CEHB_REG_INT_CLEAR, 1);
		rd(`CEHB_REG_INT_REASON, 0);
		`CHK(irq_q, 1'b0)
		wr(`CEHB_REG_WR_PTR, 32'h40);
		for (c = 1; c < 7; c++)
		begin
			lat <= c[0] ? 4'h1 : 4'hc;
			wr(`CEHB_REG_CMD, c);
			if (!c[0])
				rd(`CEHB_REG_BUSY, 1);
			wait_idle;
			rd(`CEHB_REG_INT_REASON, 1 << c);
			wr(`CEHB_REG_INT_CLEAR, 1 << c);
		end
		issue(`CEHB_CMD_QUICK);
		rd(`CEHB_REG_INT_REASON, 0);
		wr(`CEHB_REG_INT_EN, 8);
		issue(`CEHB_CMD_SEQ_INIT);
		rd(`CEHB_REG_INT_REASON, 2);
		`CHK(irq_q, 1'b0)
		issue(`CEHB_CMD_PIC_RUN);
		rd(`CEHB_REG_INT_REASON, 32'ha);
		`CHK(irq_q, 1'b1)
		wr(`CEHB_REG_INT_EN, 0);
		rd(`CEHB_REG_INT_EN, 0);
		`CHK(irq_q, 1'b0)
		wr(`CEHB_REG_INT_CLEAR, 32'h3ff);
		wr(`CEHB_REG_STD, 1);
		issue(`CEHB_CMD_PIC_RUN);
		`CHK(seen, 1)
		issue(`CEHB_CMD_PIC_RUN);
		`CHK(seen, 0)
		rd(`CEHB_REG_INT_REASON, 8);
		wr(`CEHB_REG_INT_CLEAR, 32'h3ff);
		wr(`CEHB_REG_INST_MODE, 1);
		wr(`CEHB_REG_BUF_START, 32'h100);
		wr(`CEHB_REG_BUF_END, 32'h200);
		wr(`CEHB_REG_WR_PTR, 32'h1f0);
		wr(`CEHB_REG_WR_ADD, 32'h20);
		rd(`CEHB_REG_WR_PTR, 32'h110);
		wr(`CEHB_REG_RD_PTR, 32'h1f8);
		consume(2'h0, 32'h10);
		rd(`CEHB_REG_RD_PTR, 32'h108);
		wr(`CEHB_REG_RD_PTR, 32'h1f8);
		consume(2'h1, 32'h10);
		rd(`CEHB_REG_RD_PTR, 32'h208);
		wr(`CEHB_REG_RD_PTR, 32'h110);
		wr(`CEHB_REG_STRM_CTRL, 2);
		wr(`CEHB_REG_CMD, 3);
		repeat (4) @(posedge core_clk);
		#1 `CHK(stream_stall_q, 1'b1)
		wr(`CEHB_REG_WR_ADD, 32'h40);
		wait_idle;
		rd(`CEHB_REG_INT_REASON, 32'h88);
		wr(`CEHB_REG_STRM_CTRL, 0);
		wr(`CEHB_REG_INT_CLEAR, 32'h3ff);
		save_used <= 32'h1401;
		rd(`CEHB_REG_INT_REASON, 32'h200);
		wr(`CEHB_REG_RUN, 0);
		#1 `CHK(core_run_q, 1'b0)
		conclude;
	end
endmodule
